// File: rtl/tmode_defs.vh
// Constants for the timer mode registers and frequency-output generator
`ifndef TMODE_DEFS_VH
`define TMODE_DEFS_VH
// Timer 0 mode fields
`define T0_CLKSEL_BIT   0
`define T0_RUN_BIT      3
// Timer 1 mode fields
`define T1_CLKSEL_BIT   0
`define T1_SRC_BIT      1
`define T1_OUTSEL_BIT   2
`define T1_RUN_BIT      3
// Waveform-select fields
`define WS_MODE_HI      7
`define WS_MODE_LO      6
`define WS_MODE_LOW     2'h0
`define WS_MODE_HIGH    2'h1
`define WS_MODE_FOSC1   2'h2
`define WS_MODE_FOSC8   2'h3
// Reset values
`define MODE_RESET      4'h0
`define WS_RESET        8'h00
// Prescaler taps: output of divider bit n toggles at Fosc/2^(n+1)
`define DIV_W           15
`define TAP_FOSC4       1
`define TAP_FOSC8       2
`define TAP_FOSC64      5
`define TAP_FOSC256     7
`define TAP_FOSC512     8
`define TAP_FOSC1024    9
`define TAP_FOSC4096    11
`define TAP_FOSC8192    12
`define TAP_FOSC16384   13
`define TAP_FOSC32768   14
`endif

// File: rtl/timer_mode_and_freq_output.v
// Timer mode registers, timer clock selection and frequency-output generator
`timescale 1ns/1ps
`include "tmode_defs.vh"
module timer_mode_and_freq_output (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Instruction load strobes and immediate operand
  input  wire       load_waveform,
  input  wire       load_timer0_mode,
  input  wire       load_timer1_mode,
  input  wire [7:0] imm_data,
  // External timer 1 clock pin
  input  wire       port_c_line0,
  // Timer 1 frequency from the timer 1 counter
  input  wire       timer1_freq,
  // Timer clock ticks and run controls
  output reg        timer0_tick,
  output wire       timer0_run,
  output reg        timer1_tick,
  output wire       timer1_run,
  // Register contents
  output wire [3:0] timer0_mode,
  output wire [3:0] timer1_mode,
  output wire [7:0] waveform_select,
  // Frequency-output pin
  output reg        freq_output_pin
);

  // Sizes of the stored fields
  localparam MODE_W = 4;
  localparam WAVE_W = 8;
  localparam TONE_N = 6;

  // Stored register contents
  reg  [MODE_W-1:0] timer0_mode_reg;
  reg  [MODE_W-1:0] timer1_mode_reg;
  reg  [WAVE_W-1:0] waveform_reg;

  // Free-running prescaler, its one-cycle-old copy and the half-rate toggle
  reg  [`DIV_W-1:0] div_reg;
  reg  [`DIV_W-1:0] div_prev_reg;
  reg               fosc1_reg;

  // Synchroniser stages for the asynchronous inputs
  reg  [1:0]        pc0_sync_reg;
  reg               pc0_prev_reg;
  reg  [1:0]        f1_sync_reg;

  // Combinational next values
  reg               carrier_next;
  reg               wave_next;
  reg               pin_next;

  // Decoded mode fields
  wire              t0_clk_slow;
  wire              t1_clk_slow;
  wire              t1_clk_ext;
  wire              pin_from_timer;
  wire [1:0]        carrier_mode;

  // Prescaler ticks and tones
  wire              t0_fast_rise;
  wire              t0_slow_rise;
  wire              t0_rise;
  wire              t1_div_rise;
  wire              t1_int_tick;
  wire              t1_ext_tick;
  wire              t1_src_tick;
  wire [TONE_N-1:0] tone_taps;
  wire [TONE_N-1:0] tone_hits;
  wire              tone_block;

  // Clean copies of the pins, taken from the second stage only
  wire              pc0_clean;
  wire              f1_clean;

  // Rising edge of a divider stage gives a one-cycle tick at that rate
  function rise_at;
    input [`DIV_W-1:0] cur;
    input [`DIV_W-1:0] prev;
    input integer      tap;
    begin
      rise_at = cur[tap] & ~prev[tap];
    end
  endfunction

  // Divider stage that feeds each waveform-select tone bit
  function integer tone_tap;
    input integer idx;
    begin
      case (idx)
        0:       tone_tap = `TAP_FOSC256;
        1:       tone_tap = `TAP_FOSC512;
        2:       tone_tap = `TAP_FOSC4096;
        3:       tone_tap = `TAP_FOSC8192;
        4:       tone_tap = `TAP_FOSC16384;
        default: tone_tap = `TAP_FOSC32768;
      endcase
    end
  endfunction

  // Timer 0 mode loads the low nibble of the immediate in one cycle
  // A load in the same cycle as reset is dropped; reset wins
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      timer0_mode_reg <= `MODE_RESET;
    end else if (load_timer0_mode) begin
      timer0_mode_reg <= imm_data[3:0];
    end
  end

  // Timer 1 mode loads the low nibble of the immediate in one cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      timer1_mode_reg <= `MODE_RESET;
    end else if (load_timer1_mode) begin
      timer1_mode_reg <= imm_data[3:0];
    end
  end

  // Waveform select takes all eight bits of the immediate
  // Several strobes in one cycle all act, each on its own register
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      waveform_reg <= `WS_RESET;
    end else if (load_waveform) begin
      waveform_reg <= imm_data;
    end
  end

  // Free-running prescaler; every tap is a power-of-two division
  // Wraps every 32768 cycles, so the slowest tone is its top bit
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_reg <= {`DIV_W{1'b0}};
    end else begin
      div_reg <= div_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // Delayed copy for edge detection; both clear together, so no false edge
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_prev_reg <= {`DIV_W{1'b0}};
    end else begin
      div_prev_reg <= div_reg;
    end
  end

  // Half-rate toggle, the fastest tone the clock allows
  // A true clock-rate tone cannot come out of a registered pin
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fosc1_reg <= 1'b0;
    end else begin
      fosc1_reg <= ~fosc1_reg;
    end
  end

  // External timer 1 clock passes two stages
  // Adds about three cycles of latency to each external tick
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pc0_sync_reg <= 2'h0;
    end else begin
      pc0_sync_reg <= {pc0_sync_reg[0], port_c_line0};
    end
  end

  // History of the clean external clock for the falling-edge detect
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pc0_prev_reg <= 1'b0;
    end else begin
      pc0_prev_reg <= pc0_clean;
    end
  end

  // Timer 1 frequency passes two stages before it may reach the pin
  // Its edges show at the pin three cycles late
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      f1_sync_reg <= 2'h0;
    end else begin
      f1_sync_reg <= {f1_sync_reg[0], timer1_freq};
    end
  end

  // Only the second stage is read by logic
  assign pc0_clean = pc0_sync_reg[1];
  assign f1_clean  = f1_sync_reg[1];

  // Mode field decode; timer 0 bits 1 and 2 are never decoded
  // Those reserved bits stay visible through timer0_mode
  assign t0_clk_slow    = timer0_mode_reg[`T0_CLKSEL_BIT];
  assign t1_clk_slow    = timer1_mode_reg[`T1_CLKSEL_BIT];
  assign t1_clk_ext     = timer1_mode_reg[`T1_SRC_BIT];
  assign pin_from_timer = timer1_mode_reg[`T1_OUTSEL_BIT];
  assign carrier_mode   = waveform_reg[`WS_MODE_HI:`WS_MODE_LO];

  // Run controls go straight to the counters
  assign timer0_run = timer0_mode_reg[`T0_RUN_BIT];
  assign timer1_run = timer1_mode_reg[`T1_RUN_BIT];

  // Timer 0 base clock taps
  // Switching taps mid-period may give one short or long interval
  assign t0_fast_rise = rise_at(div_reg, div_prev_reg, `TAP_FOSC4);
  assign t0_slow_rise = rise_at(div_reg, div_prev_reg, `TAP_FOSC1024);
  assign t0_rise      = t0_clk_slow ? t0_slow_rise : t0_fast_rise;

  // Timer 1 internal clock is every cycle or every 64th cycle
  assign t1_div_rise = rise_at(div_reg, div_prev_reg, `TAP_FOSC64);
  assign t1_int_tick = t1_clk_slow ? t1_div_rise : 1'b1;

  // External source counts falling edges of the synchronised pin
  // Pulses shorter than one clock may be missed
  assign t1_ext_tick = pc0_prev_reg & ~pc0_clean;
  assign t1_src_tick = t1_clk_ext ? t1_ext_tick : t1_int_tick;

  // Timer 0 tick is gated by run, so ticks stop one cycle after run clears
  // Registered so the counter sees a clean one-cycle pulse
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      timer0_tick <= 1'b0;
    end else begin
      timer0_tick <= t0_rise & timer0_run;
    end
  end

  // Timer 1 tick is gated the same way
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      timer1_tick <= 1'b0;
    end else begin
      timer1_tick <= t1_src_tick & timer1_run;
    end
  end

  // Divided tones for waveform bits 0..5
  // All tones share the prescaler, so they stay phase-locked
  genvar gi;
  generate
    for (gi = 0; gi < TONE_N; gi = gi + 1) begin : g_tone
      assign tone_taps[gi] = div_reg[tone_tap(gi)];
    end
  endgenerate

  // Any enabled tone that is high blanks the carrier
  // With no tone bit set the carrier passes untouched
  assign tone_hits  = waveform_reg[5:0] & tone_taps;
  assign tone_block = |tone_hits;

  // Carrier chosen by the two top waveform bits
  // The fastest carrier runs at half the clock rate
  always @* begin
    case (carrier_mode)
      `WS_MODE_LOW:   carrier_next = 1'b0;
      `WS_MODE_HIGH:  carrier_next = 1'b1;
      `WS_MODE_FOSC1: carrier_next = fosc1_reg;
      `WS_MODE_FOSC8: carrier_next = div_reg[`TAP_FOSC8];
      default:        carrier_next = 1'b0;
    endcase
  end

  // Waveform generator output: carrier with the tones cut out
  always @* begin
    wave_next = carrier_next & ~tone_block;
  end

  // Pin source: generator waveform or timer 1 frequency
  // The timer frequency bypasses the generator entirely when chosen
  always @* begin
    pin_next = pin_from_timer ? f1_clean : wave_next;
  end

  // Registered pin output, low straight out of reset
  // Registering keeps glitches of the tone mix off the pad
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      freq_output_pin <= 1'b0;
    end else begin
      freq_output_pin <= pin_next;
    end
  end

  // Register contents for the rest of the core
  assign timer0_mode     = timer0_mode_reg;
  assign timer1_mode     = timer1_mode_reg;
  assign waveform_select = waveform_reg;

endmodule

// File: tb/core_model.sv
// Model of the core issuing load instructions
`timescale 1ns/1ps
module core_model (
  // Clock
  input  wire       clk_sys,
  // Load strobes and immediate operand
  output reg        load_waveform    = 1'b0,
  output reg        load_timer0_mode = 1'b0,
  output reg        load_timer1_mode = 1'b0,
  output reg  [7:0] imm_data         = 8'h00
);
  // One load per machine cycle, kind 3 idle
  task exec(input [1:0] k, input [7:0] d);
    load_waveform <= k == 2'h0;
    load_timer0_mode <= k == 2'h1;
    load_timer1_mode <= k == 2'h2;
    imm_data <= d;
    @(posedge clk_sys);
  endtask
endmodule

// File: tb/tmode_sva.sv
// Port assertions for the timer mode block
`timescale 1ns/1ps
module tmode_sva (
  // Clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // Load strobes and operand
  input wire       load_waveform,
  input wire       load_timer0_mode,
  input wire       load_timer1_mode,
  input wire [7:0] imm_data,
  // Watched outputs
  input wire       timer0_tick,
  input wire       timer1_tick,
  input wire       freq_output_pin,
  input wire [7:0] waveform_select,
  input wire [3:0] timer0_mode,
  input wire [3:0] timer1_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_l0; load_timer0_mode |=> timer0_mode == $past(imm_data[3:0]); endproperty
  a_l0: assert property (p_l0) else $error("t0 load");
  property p_l1; load_timer1_mode |=> timer1_mode == $past(imm_data[3:0]); endproperty
  a_l1: assert property (p_l1) else $error("t1 load");
  property p_lw; load_waveform |=> waveform_select == $past(imm_data); endproperty
  a_lw: assert property (p_lw) else $error("ws load");
  property p_s0; !timer0_mode[3] [*2] |-> !timer0_tick; endproperty
  a_s0: assert property (p_s0) else $error("t0 stop");
  property p_s1; !timer1_mode[3] [*2] |-> !timer1_tick; endproperty
  a_s1: assert property (p_s1) else $error("t1 stop");
  property p_t1; (timer1_mode == 4'h8) [*2] |-> timer1_tick; endproperty
  a_t1: assert property (p_t1) else $error("t1 rate");
  property p_lo; (waveform_select[7:6] == 2'h0 && !timer1_mode[2]) [*2] |-> !freq_output_pin; endproperty
  a_lo: assert property (p_lo) else $error("pin low");
  property p_hi; (waveform_select == 8'h40 && !timer1_mode[2]) [*2] |-> freq_output_pin; endproperty
  a_hi: assert property (p_hi) else $error("pin high");
  c_ws: cover property (load_waveform);
  c_t0: cover property (timer0_tick);
  c_t1: cover property (timer1_tick);
endmodule
bind timer_mode_and_freq_output tmode_sva u_sva (.*);

// File: tb/timer_mode_and_freq_output_tb.sv
// Self-checking bench for the timer mode block
`timescale 1ns/1ps
module timer_mode_and_freq_output_tb;
  reg clk_sys = 1'b0, rst_n = 1'b0, port_c_line0 = 1'b0, timer1_freq = 1'b0, last;
  reg [3:0] cyc = 4'h0;
  wire load_waveform, load_timer0_mode, load_timer1_mode, timer0_tick, timer0_run, timer1_tick, timer1_run;
  wire freq_output_pin;
  wire [7:0] imm_data, waveform_select;
  wire [3:0] timer0_mode, timer1_mode;
  integer errors = 0, checks = 0, tg, n0, n1;
  always #25 clk_sys = ~clk_sys;
  // External clock of period 8, timer 1 frequency of period 16
  always @(posedge clk_sys) {timer1_freq, port_c_line0, cyc} <= {cyc[3], cyc[2], cyc + 4'h1};
  core_model u_core (.*);
  timer_mode_and_freq_output u_dut (.*);
  task chk(input string s, input [47:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp) errors = errors + 1;
    if (seen !== exp) $display("BAD %s exp %h seen %h", s, exp, seen);
  endtask
  // Load modes and waveform back to back, then count pin changes and ticks
  task run(input [7:0] a, b, w, input [15:0] n, input [47:0] e);
    u_core.exec(2'h1, a);
    u_core.exec(2'h2, b);
    u_core.exec(2'h0, w);
    u_core.exec(2'h3, ~w);
    repeat (4) @(negedge clk_sys);
    chk("regs", {timer0_mode, timer1_mode, waveform_select}, {a[3:0], b[3:0], w});
    chk("runs", {timer0_run, timer1_run}, {a[3], b[3]});
    {last, tg, n0, n1} = {freq_output_pin, 96'h0};
    repeat (n) begin
      @(negedge clk_sys);
      {tg, last} = {tg + (freq_output_pin !== last), freq_output_pin};
      {n0, n1} = {n0 + timer0_tick, n1 + timer1_tick};
    end
    chk("counts", {tg[15:0], n0[15:0], n1[15:0]}, e);
    @(posedge clk_sys);
  endtask
  task end_of_test;
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #500000 errors = errors + 1;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("rst", {waveform_select, timer0_mode, timer1_mode, freq_output_pin}, 48'h0);
    @(posedge clk_sys);
    run(8'h08, 8'h08, 8'h00, 16'h0400, 48'h000001000400);
    run(8'h09, 8'h09, 8'h40, 16'h0800, 48'h000000020020);
    run(8'h0e, 8'h00, 8'h80, 16'h0040, 48'h004000100000);
    run(8'h00, 8'h00, 8'hc0, 16'h0040, 48'h001000000000);
    run(8'h01, 8'h0a, 8'h41, 16'h0200, 48'h000400000040);
    run(8'hf0, 8'hf4, 8'h40, 16'h0040, 48'h000800000000);
    end_of_test;
  end
endmodule
